/* src/ae_dev.sv */
// encoder end: position latch, preset, direction, status and serial output
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "ae_regs.svh"
module ae_dev #(
  parameter int unsigned PWRON_CYC = `AE_PWRON_CYC,
  parameter int unsigned SET_DLY_CYC = `AE_SET_DLY_CYC,
  parameter int unsigned SET_TMO_CYC = `AE_SET_TMO_CYC,
  parameter int unsigned SET_PROC_CYC = `AE_SET_PROC_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to the serial master
  ae_link_if.dev lnk,
  // sensor side
  input wire logic [`AE_RES-1:0] pos_raw,
  input wire logic alarm_in,
  output logic ready
);
  // ----------------------------------------
  // state and pin synchronisers
  // ----------------------------------------
  ae_pkg::ae_dev_st_t s_r;
  ae_pkg::ae_dev_st_t s_nxt;
  logic [2:0] pin_s;
  logic lclk_s;
  logic set_s;
  logic dir_s;

  ae_sync #(
    .W(3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({lnk.lclk, lnk.preset, lnk.dir}),
    .q(pin_s)
  );

  assign lclk_s = pin_s[2];
  assign set_s = pin_s[1];
  assign dir_s = pin_s[0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic dir_eff;
    logic fall;
    logic rise;
    logic tog;
    logic nerr;
    logic [`AE_RES-1:0] sensed;
    logic [`AE_RES-1:0] cur;
    logic [`AE_RES-1:0] code;
    logic [`AE_FR_MAX-1:0] fresh;
    logic [`AE_IDX_W-1:0] flen;
    logic [`AE_MONO_W-1:0] mlim;
    dir_eff = 1'h0;
    fall = 1'h0;
    rise = 1'h0;
    tog = 1'h0;
    nerr = 1'h0;
    sensed = '0;
    cur = '0;
    code = '0;
    fresh = '0;
    flen = '0;
    mlim = '0;
    s_nxt = s_r;

    // power-on wait; position is not trusted until it ends
    if (!s_r.ready) begin
      s_nxt.warm_cnt = s_r.warm_cnt + 1'h1;
      if (s_r.warm_cnt == `AE_CNT_W'(PWRON_CYC - 1)) begin
        s_nxt.ready = 1'h1;
      end
    end

    // counting sense; the factory setting may invert the pin
    dir_eff = dir_s ^ `AE_DIR_REV;
    s_nxt.dir_q = dir_eff;
    // a flip seen after power-on is an error until the next power cycle
    if (s_r.ready && (dir_eff != s_r.dir_q)) begin
      s_nxt.dir_err = 1'h1;
    end
    // complement reverses the sense at once, well inside the response time
    sensed = dir_eff ? ~pos_raw : pos_raw;
    cur = sensed - s_r.offset + `AE_PRESET_VAL;
    if (!s_r.frz) begin
      s_nxt.pos_hold = cur;
    end

    // ----------------------------------------
    // preset sequence
    // ----------------------------------------
    case (s_r.ps)
      ae_pkg::AE_P_IDLE: begin
        if (set_s) begin
          s_nxt.ps = ae_pkg::AE_P_DLY;
          s_nxt.ps_cnt = '0;
        end
      end
      ae_pkg::AE_P_DLY: begin
        if (!set_s) begin
          s_nxt.ps = ae_pkg::AE_P_IDLE;
        end else if (s_r.ps_cnt == `AE_CNT_W'(SET_DLY_CYC - 1)) begin
          s_nxt.offset = sensed;
          s_nxt.frz = 1'h1;
          s_nxt.frz_cnt = '0;
          s_nxt.ps = ae_pkg::AE_P_TMO;
          s_nxt.ps_cnt = '0;
        end else begin
          s_nxt.ps_cnt = s_r.ps_cnt + 1'h1;
        end
      end
      ae_pkg::AE_P_TMO: begin
        // no new preset is armed until the timeout ends and the pin is low
        if (s_r.ps_cnt != `AE_CNT_W'(SET_TMO_CYC - 1)) begin
          s_nxt.ps_cnt = s_r.ps_cnt + 1'h1;
        end else if (!set_s) begin
          s_nxt.ps = ae_pkg::AE_P_IDLE;
        end
      end
      default: begin
        s_nxt.ps = ae_pkg::AE_P_IDLE;
      end
    endcase

    // the published word keeps its old value while the preset settles
    if (s_r.frz) begin
      s_nxt.frz_cnt = s_r.frz_cnt + 1'h1;
      if (s_r.frz_cnt == `AE_CNT_W'(SET_PROC_CYC - 1)) begin
        s_nxt.frz = 1'h0;
      end
    end

    // ----------------------------------------
    // status line
    // ----------------------------------------
    s_nxt.flt = !s_r.ready | s_r.dir_err | alarm_in;
    nerr = !s_r.flt;

    // ----------------------------------------
    // frame word
    // ----------------------------------------
    code = `AE_GRAY ? (s_r.pos_hold ^ (s_r.pos_hold >> 1)) : s_r.pos_hold;
    if (`AE_BISS) begin
      // start bit, position, error bit, inverted crc; always binary
      fresh = {1'h1, s_r.pos_hold, nerr, ~ae_pkg::ae_crc({s_r.pos_hold, nerr})};
      flen = `AE_BISS_LEN;
      mlim = `AE_MONO_W'(`AE_BISS_TO_CYC - 1);
    end else begin
      fresh = {code, 8'h00};
      flen = `AE_SSI_LEN;
      mlim = `AE_MONO_W'(`AE_MONO_CYC - 1);
    end

    // ----------------------------------------
    // serial link
    // ----------------------------------------
    s_nxt.lc_q = lclk_s;
    fall = s_r.lc_q & ~lclk_s;
    rise = ~s_r.lc_q & lclk_s;
    tog = fall | rise;
    case (s_r.lnk)
      ae_pkg::AE_L_IDLE: begin
        s_nxt.sd = `AE_SD_IDLE;
        if (fall) begin
          // monoflop expired: take a fresh position
          s_nxt.word = fresh;
          s_nxt.shf = fresh << 1;
          s_nxt.sd = fresh[`AE_FR_MAX-1];
          s_nxt.idx = `AE_IDX_W'(1);
          s_nxt.mono = '0;
          s_nxt.lnk = ae_pkg::AE_L_ACT;
        end
      end
      ae_pkg::AE_L_ACT: begin
        if (tog) begin
          s_nxt.mono = '0;
        end else if (s_r.mono == mlim) begin
          s_nxt.lnk = ae_pkg::AE_L_IDLE;
          s_nxt.sd = `AE_SD_IDLE;
        end else begin
          s_nxt.mono = s_r.mono + 1'h1;
        end
        if (fall && (s_r.idx == flen)) begin
          // clock back inside the monoflop time: same word again
          s_nxt.shf = s_r.word << 1;
          s_nxt.sd = s_r.word[`AE_FR_MAX-1];
          s_nxt.idx = `AE_IDX_W'(1);
        end else if (fall) begin
          s_nxt.shf = s_r.shf << 1;
          s_nxt.sd = s_r.shf[`AE_FR_MAX-1];
          s_nxt.idx = s_r.idx + 1'h1;
        end else if (rise && (s_r.idx == flen)) begin
          // data held low while the monoflop runs
          s_nxt.sd = `AE_SD_LOW;
        end
      end
      default: begin
        s_nxt.lnk = ae_pkg::AE_L_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.sd <= `AE_SD_IDLE;
      s_r.flt <= 1'h1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign lnk.sd = s_r.sd;
  assign lnk.stat_o = `AE_STAT_ACT;
  assign lnk.stat_oe = s_r.flt;
  assign ready = s_r.ready;
endmodule

/* src/ae_host.sv */
// master end: apb registers, link clock divider, frame capture, preset and direction pins
`timescale 1ns/1ns
`include "ae_regs.svh"
module ae_host #(
  parameter int unsigned PWRON_CYC = `AE_PWRON_CYC,
  parameter int unsigned SET_MIN_CYC = `AE_SET_MIN_CYC,
  parameter int unsigned SET_WAIT_CYC = `AE_SET_WAIT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`AE_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to the encoder
  ae_link_if.host lnk
);
  ae_pkg::ae_host_st_t s_r;
  ae_pkg::ae_host_st_t s_nxt;
  logic [1:0] pin_s;

  ae_sync #(
    .W(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({lnk.sd, lnk.stat}),
    .q(pin_s)
  );

  always_comb begin
    logic wr;
    logic ok;
    logic [`AE_HALF_W-1:0] hlim;
    logic [`AE_IDX_W-1:0] flen;
    logic [`AE_RES-1:0] code;
    wr = psel & penable & pwrite;
    ok = 1'h0;
    hlim = s_r.biss ? `AE_HALF_W'(`AE_HALF_BISS - 1) : `AE_HALF_W'(`AE_HALF_SSI - 1);
    flen = s_r.biss ? `AE_BISS_LEN : `AE_SSI_LEN;
    code = s_r.rx[`AE_RES-1:0];
    s_nxt = s_r;

    // ----------------------------------------
    // power-on wait
    // ----------------------------------------
    if (!s_r.warm) begin
      s_nxt.warm_cnt = s_r.warm_cnt + 1'h1;
      if (s_r.warm_cnt == `AE_CNT_W'(PWRON_CYC - 1)) begin
        s_nxt.warm = 1'h1;
      end
    end

    // ----------------------------------------
    // register access; read data prepared in the setup cycle
    // ----------------------------------------
    if (psel && !penable) begin
      s_nxt.prdata = '0;
      s_nxt.slverr = 1'h0;
      case (paddr)
        `AE_REG_CTRL: begin
          s_nxt.prdata[`AE_CTRL_BISS] = s_r.biss;
          s_nxt.prdata[`AE_CTRL_GRAY] = s_r.gray;
          s_nxt.prdata[`AE_CTRL_DIR] = s_r.dir;
        end
        `AE_REG_STAT: begin
          s_nxt.prdata[`AE_STAT_BUSY] = (s_r.st != ae_pkg::AE_H_IDLE);
          s_nxt.prdata[`AE_STAT_DONE] = s_r.done;
          s_nxt.prdata[`AE_STAT_CRCERR] = s_r.crc_err;
          s_nxt.prdata[`AE_STAT_FAULT] = ~pin_s[0];
          s_nxt.prdata[`AE_STAT_WARM] = s_r.warm;
          s_nxt.prdata[`AE_STAT_SETBSY] = s_r.set_act;
        end
        `AE_REG_POS: begin
          s_nxt.prdata[`AE_RES-1:0] = s_r.pos;
        end
        default: begin
          s_nxt.slverr = 1'h1;
        end
      endcase
    end
    if (wr && (paddr == `AE_REG_CTRL)) begin
      s_nxt.biss = pwdata[`AE_CTRL_BISS];
      s_nxt.gray = pwdata[`AE_CTRL_GRAY];
      s_nxt.dir = pwdata[`AE_CTRL_DIR];
      if (pwdata[`AE_CTRL_SET] && !s_r.set_act) begin
        s_nxt.set_act = 1'h1;
        s_nxt.preset = 1'h1;
        s_nxt.set_cnt = '0;
      end
    end
    if (wr && (paddr == `AE_REG_STAT) && pwdata[`AE_STAT_DONE]) begin
      s_nxt.done = 1'h0;
    end

    // ----------------------------------------
    // preset pulse and settling wait
    // ----------------------------------------
    if (s_r.set_act) begin
      s_nxt.set_cnt = s_r.set_cnt + 1'h1;
      if (s_r.set_cnt == `AE_CNT_W'(SET_MIN_CYC - 1)) begin
        s_nxt.preset = 1'h0;
      end
      if (s_r.set_cnt == `AE_CNT_W'(SET_WAIT_CYC - 1)) begin
        s_nxt.set_act = 1'h0;
      end
    end

    // ----------------------------------------
    // frame: clock falls, data sampled at each rise
    // ----------------------------------------
    case (s_r.st)
      ae_pkg::AE_H_IDLE: begin
        s_nxt.lclk = `AE_LCLK_IDLE;
        // refused before warm-up so no early word is ever reported
        if (wr && (paddr == `AE_REG_CTRL) && pwdata[`AE_CTRL_GO] && s_r.warm) begin
          s_nxt.st = ae_pkg::AE_H_LOW;
          s_nxt.lclk = 1'h0;
          s_nxt.half = '0;
          s_nxt.bit_idx = '0;
        end
      end
      ae_pkg::AE_H_LOW: begin
        if (s_r.half == hlim) begin
          s_nxt.st = ae_pkg::AE_H_HIGH;
          s_nxt.half = '0;
          s_nxt.lclk = 1'h1;
          s_nxt.rx = {s_r.rx[`AE_FR_MAX-2:0], pin_s[1]};
          s_nxt.bit_idx = s_r.bit_idx + 1'h1;
        end else begin
          s_nxt.half = s_r.half + 1'h1;
        end
      end
      ae_pkg::AE_H_HIGH: begin
        if (s_r.half != hlim) begin
          s_nxt.half = s_r.half + 1'h1;
        end else if (s_r.bit_idx == flen) begin
          s_nxt.st = ae_pkg::AE_H_END;
        end else begin
          s_nxt.st = ae_pkg::AE_H_LOW;
          s_nxt.half = '0;
          s_nxt.lclk = 1'h0;
        end
      end
      ae_pkg::AE_H_END: begin
        if (s_r.biss) begin
          ok = s_r.rx[`AE_FR_MAX-1] &
               (~s_r.rx[`AE_CRC_W-1:0] == ae_pkg::ae_crc(s_r.rx[`AE_FR_MAX-2:`AE_CRC_W]));
          code = s_r.rx[`AE_FR_MAX-2 -: `AE_RES];
        end else begin
          ok = 1'h1;
          code = s_r.gray ? ae_pkg::ae_gray2bin(s_r.rx[`AE_RES-1:0]) : s_r.rx[`AE_RES-1:0];
        end
        if (ok) begin
          s_nxt.pos = code;
        end
        s_nxt.crc_err = ~ok;
        s_nxt.done = 1'h1;
        s_nxt.st = ae_pkg::AE_H_IDLE;
      end
      default: begin
        s_nxt.st = ae_pkg::AE_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.lclk <= `AE_LCLK_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // zero-wait slave; read data was registered in the setup cycle
  assign pready = psel & penable;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.slverr;
  assign lnk.lclk = s_r.lclk;
  assign lnk.preset = s_r.preset;
  assign lnk.dir = s_r.dir;
endmodule

/* src/ae_link_if.sv */
// link wires between the serial master and the encoder
`timescale 1ns/1ns
`include "ae_regs.svh"
interface ae_link_if;
  logic lclk;
  logic sd;
  logic preset;
  logic dir;
  logic stat_o;
  logic stat_oe;
  logic stat;
  // open collector with pull-up: the line is low only while the encoder pulls it
  assign stat = stat_oe ? stat_o : `AE_STAT_PULL;
  modport dev (input lclk, input preset, input dir, output sd, output stat_o, output stat_oe);
  modport host (output lclk, output preset, output dir, input sd, input stat);
endinterface

/* src/ae_pkg.sv */
// types and helper functions of the absolute encoder serial port
`include "ae_regs.svh"
package ae_pkg;
  typedef enum logic [0:0] {AE_L_IDLE = 1'h0, AE_L_ACT = 1'h1} ae_lnk_t;
  typedef enum logic [1:0] {AE_P_IDLE = 2'h0, AE_P_DLY = 2'h1, AE_P_TMO = 2'h2} ae_set_t;
  typedef enum logic [1:0] {AE_H_IDLE = 2'h0, AE_H_LOW = 2'h1, AE_H_HIGH = 2'h2, AE_H_END = 2'h3} ae_hst_t;

  typedef struct packed {
    logic [`AE_CNT_W-1:0] warm_cnt;
    logic ready;
    logic dir_q;
    logic dir_err;
    ae_set_t ps;
    logic [`AE_CNT_W-1:0] ps_cnt;
    logic frz;
    logic [`AE_CNT_W-1:0] frz_cnt;
    logic [`AE_RES-1:0] offset;
    logic [`AE_RES-1:0] pos_hold;
    ae_lnk_t lnk;
    logic lc_q;
    logic [`AE_MONO_W-1:0] mono;
    logic [`AE_IDX_W-1:0] idx;
    logic [`AE_FR_MAX-1:0] word;
    logic [`AE_FR_MAX-1:0] shf;
    logic sd;
    logic flt;
  } ae_dev_st_t;

  typedef struct packed {
    logic [`AE_CNT_W-1:0] warm_cnt;
    logic warm;
    ae_hst_t st;
    logic [`AE_HALF_W-1:0] half;
    logic [`AE_IDX_W-1:0] bit_idx;
    logic [`AE_FR_MAX-1:0] rx;
    logic [`AE_RES-1:0] pos;
    logic done;
    logic crc_err;
    logic biss;
    logic gray;
    logic dir;
    logic set_act;
    logic preset;
    logic [`AE_CNT_W-1:0] set_cnt;
    logic lclk;
    logic [31:0] prdata;
    logic slverr;
  } ae_host_st_t;

  // crc6 over position and error bit, msb first
  function automatic logic [`AE_CRC_W-1:0] ae_crc(input logic [`AE_RES:0] d);
    logic [`AE_CRC_W-1:0] c;
    logic fb;
    c = '0;
    for (int i = `AE_RES; i >= 0; i--) begin
      fb = c[`AE_CRC_W-1] ^ d[i];
      c = {c[`AE_CRC_W-2:0], 1'h0} ^ (fb ? `AE_CRC_POLY : 6'h00);
    end
    return c;
  endfunction

  function automatic logic [`AE_RES-1:0] ae_gray2bin(input logic [`AE_RES-1:0] g);
    logic [`AE_RES-1:0] b;
    b = g;
    for (int i = `AE_RES - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage

/* src/ae_regs.svh */
// constants of the absolute encoder serial port and its master register map
`ifndef AE_REGS_SVH
`define AE_REGS_SVH
// ----------------------------------------
// clock
// ----------------------------------------
`define AE_CLK_KHZ 250000
`define AE_CLK_MHZ 250
// ----------------------------------------
// factory settings of the encoder
// ----------------------------------------
`define AE_RES 17
`define AE_GRAY 1'h0
`define AE_BISS 1'h0
`define AE_DIR_REV 1'h0
`define AE_PRESET_VAL 17'h00000
// ----------------------------------------
// frame layout
// ----------------------------------------
`define AE_FR_MAX 25
`define AE_SSI_LEN 5'h11
`define AE_BISS_LEN 5'h19
`define AE_IDX_W 5
`define AE_CRC_W 6
`define AE_CRC_POLY 6'h03
`define AE_SD_IDLE 1'h1
`define AE_SD_LOW 1'h0
`define AE_LCLK_IDLE 1'h1
`define AE_STAT_PULL 1'h1
`define AE_STAT_ACT 1'h0
// ----------------------------------------
// times and derived cycle counts
// ----------------------------------------
`define AE_CNT_W 26
`define AE_PWRON_MS 150
`define AE_PWRON_CYC (`AE_PWRON_MS * `AE_CLK_KHZ)
`define AE_MONO_NS 15000
`define AE_MONO_CYC (`AE_MONO_NS * `AE_CLK_MHZ / 1000)
`define AE_BISS_TO_NS 1000
`define AE_BISS_TO_CYC (`AE_BISS_TO_NS * `AE_CLK_MHZ / 1000)
`define AE_MONO_W 12
`define AE_SET_MIN_MS 10
`define AE_SET_MIN_CYC (`AE_SET_MIN_MS * `AE_CLK_KHZ)
`define AE_SET_DLY_MS 1
`define AE_SET_DLY_CYC (`AE_SET_DLY_MS * `AE_CLK_KHZ)
`define AE_SET_PROC_MS 15
`define AE_SET_PROC_CYC (`AE_SET_PROC_MS * `AE_CLK_KHZ)
`define AE_SET_TMO_MS 14
`define AE_SET_TMO_CYC (`AE_SET_TMO_MS * `AE_CLK_KHZ)
`define AE_SET_WAIT_CYC ((`AE_SET_DLY_MS + `AE_SET_PROC_MS) * `AE_CLK_KHZ)
`define AE_SSI_KHZ 2000
`define AE_BISS_KHZ 10000
`define AE_HALF_SSI ((`AE_CLK_KHZ + 2 * `AE_SSI_KHZ - 1) / (2 * `AE_SSI_KHZ))
`define AE_HALF_BISS ((`AE_CLK_KHZ + 2 * `AE_BISS_KHZ - 1) / (2 * `AE_BISS_KHZ))
`define AE_HALF_W 7
// ----------------------------------------
// master register map
// ----------------------------------------
`define AE_AW 8
`define AE_REG_CTRL 8'h00
`define AE_REG_STAT 8'h04
`define AE_REG_POS 8'h08
`define AE_CTRL_GO 0
`define AE_CTRL_BISS 1
`define AE_CTRL_GRAY 2
`define AE_CTRL_DIR 3
`define AE_CTRL_SET 4
`define AE_STAT_BUSY 0
`define AE_STAT_DONE 1
`define AE_STAT_CRCERR 2
`define AE_STAT_FAULT 3
`define AE_STAT_WARM 4
`define AE_STAT_SETBSY 5
`endif

/* src/ae_sync.sv */
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module ae_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } ae_sync_st_t;

  ae_sync_st_t s_r;
  ae_sync_st_t s_nxt;

  // first stage feeds only the second
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = d;
    s_nxt.stab = s_r.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stab;
endmodule

/* verification/abs_encoder_serial_position_port_tb.sv */
// bench: host and encoder joined over the link, driven through apb
`timescale 1ns/1ns
`include "ae_regs.svh"
module abs_encoder_serial_position_port_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [`AE_AW-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [`AE_RES-1:0] pos_raw;
  logic alarm_in;
  logic dev_ready;
  logic [31:0] ctrl;
  logic [31:0] d;
  logic e;
  int n_fail;
  int compares;
  ae_link_if lnk ();
  // short counts keep the run small; busy and rearm spans stay full length since no test waits for their end
  ae_host #(.PWRON_CYC(200), .SET_MIN_CYC(200)) i_ae_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk));
  ae_dev #(.PWRON_CYC(200), .SET_DLY_CYC(50), .SET_PROC_CYC(400)) i_ae_dev (.pclk(pclk),
    .presetn(presetn), .lnk(lnk), .pos_raw(pos_raw), .alarm_in(alarm_in), .ready(dev_ready));
  ae_props i_ae_props (.pclk(pclk), .presetn(presetn), .lclk(lnk.lclk), .sd(lnk.sd),
    .preset(lnk.preset), .dir(lnk.dir), .stat_o(lnk.stat_o), .stat_oe(lnk.stat_oe), .stat(lnk.stat));
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // ----
  // shared tasks
  // ----
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task rst();
    @(posedge pclk);
    presetn <= 1'h0;
    wt(8);
    presetn <= 1'h1;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task st(input string nm, input logic [31:0] m, input logic [31:0] x);
    apb(1'h0, `AE_REG_STAT, 32'h0);
    chk(nm, d & m, x);
  endtask
  // one whole frame: start, wait for done, read and clear
  task frame(input logic [16:0] x);
    int k;
    apb(1'h1, `AE_REG_CTRL, ctrl | 32'h1);
    k = 0;
    d = 32'h0;
    while (d[`AE_STAT_DONE] !== 1'h1 && k < 9000) begin
      apb(1'h0, `AE_REG_STAT, 32'h0);
      k++;
    end
    chk("done", {31'h0, d[`AE_STAT_DONE]}, 32'h1);
    apb(1'h0, `AE_REG_POS, 32'h0);
    chk("pos", d, {15'h0, x});
    apb(1'h1, `AE_REG_STAT, 32'h2);
  endtask
  // ----
  // scenarios
  // ----
  task t_power();
    st("cold", 32'h18, 32'h08);
    chk("ready", {31'h0, dev_ready}, 32'h0);
    apb(1'h1, `AE_REG_CTRL, 32'h6);
    apb(1'h0, `AE_REG_CTRL, 32'h0);
    chk("ctrl", d, 32'h6);
    apb(1'h1, `AE_REG_CTRL, 32'h1);
    st("busy", 32'h1, 32'h0);
    wt(220);
    st("warm", 32'h18, 32'h10);
    chk("ready", {31'h0, dev_ready}, 32'h1);
    alarm_in <= 1'h1;
    wt(6);
    st("alarm", 32'h8, 32'h8);
    alarm_in <= 1'h0;
    wt(6);
    st("clear", 32'h8, 32'h0);
    apb(1'h0, 8'h0C, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    $display("t_power done");
  endtask
  task t_ssi();
    pos_raw <= 17'h1A5C3;
    frame(17'h1A5C3);
    pos_raw <= 17'h00001;
    frame(17'h1A5C3);
    wt(3900);
    frame(17'h00001);
    $display("t_ssi done");
  endtask
  task t_preset();
    pos_raw <= 17'h0ABCD;
    apb(1'h1, `AE_REG_CTRL, 32'h10);
    st("setbsy", 32'h20, 32'h20);
    wt(3900);
    frame(17'h00000);
    pos_raw <= 17'h0ABD2;
    wt(3900);
    frame(17'h00005);
    $display("t_preset done");
  endtask
  // dir set before warm is legal; toggling it later is a sticky fault
  task t_dir();
    rst();
    ctrl = 32'h8;
    apb(1'h1, `AE_REG_CTRL, ctrl);
    pos_raw <= 17'h0F0F0;
    wt(220);
    st("nofault", 32'h8, 32'h0);
    frame(17'h10F0F);
    ctrl = 32'h0;
    apb(1'h1, `AE_REG_CTRL, ctrl);
    wt(8);
    st("dirfault", 32'h8, 32'h8);
    wt(3900);
    frame(17'h0F0F0);
    st("sticky", 32'h8, 32'h8);
    $display("t_dir done");
  endtask
  task close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    close_out();
  end
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pos_raw = 17'h0;
    alarm_in = 1'h0;
    ctrl = 32'h0;
    n_fail = 0;
    compares = 0;
    rst();
    t_power();
    t_ssi();
    t_preset();
    t_dir();
    close_out();
  end
endmodule

/* verification/ae_props.sv */
// checker on the link wires between serial master and encoder
`timescale 1ns/1ns
module ae_props #(
  parameter int SET_MIN_CYC = 200
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic lclk,
  input wire logic sd,
  input wire logic preset,
  input wire logic dir,
  input wire logic stat_o,
  input wire logic stat_oe,
  input wire logic stat
);
  logic [11:0] since_r;
  logic [25:0] hi_r;
  logic lq_r;
  // saturating count so a long idle never wraps back into the frame window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_r <= 12'h000;
      hi_r <= 26'h0;
      lq_r <= 1'h1;
    end else begin
      lq_r <= lclk;
      since_r <= (lclk != lq_r) ? 12'h000 : ((since_r == 12'hFFF) ? since_r : since_r + 12'h001);
      hi_r <= preset ? hi_r + 26'h1 : 26'h0;
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_stat_act: assert property (stat_oe |-> stat_o == 1'h0 && stat == 1'h0)
    else $error("status pulled but not low");
  chk_warm_idle: assert property ($rose(presetn) |-> sd && stat_oe)
    else $error("no fault or idle data after reset");
  chk_lclk_low: assert property ($fell(lclk) |-> !lclk [*8])
    else $error("link clock low half too short");
  chk_lclk_high: assert property ($rose(lclk) |-> lclk [*8])
    else $error("link clock high half too short");
  chk_sd_settle: assert property ($changed(sd) && since_r > 12'h008 |-> since_r >= 12'hEA0 && since_r <= 12'hED0)
    else $error("data moved away from clock edge or timeout");
  chk_mono_bound: assert property (lclk && since_r == 12'hED8 |-> sd)
    else $error("data not idle after monoflop time");
  chk_preset_hold: assert property ($fell(preset) |-> hi_r + 26'h1 >= SET_MIN_CYC)
    else $error("preset pulse too short");
  chk_dir_err: assert property ($changed(dir) && !stat_oe |-> ##[1:6] stat_oe ##1 stat_oe [*8])
    else $error("direction change not flagged");
  cover property ($fell(lclk) && since_r == 12'hFFF);
  cover property ($rose(preset));
  cover property ($changed(dir) && !stat_oe);
endmodule
